// File: hdl/wtu_core.sv
// watch trace unit control register, cycle counter and event taps
module wtu_core
	import wtu_pkg::*;
#(
	parameter logic HAS_CYC = 1'b1,
	parameter logic HAS_PRF = 1'b1,
	parameter logic HAS_TRC = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// processor core
	input wire logic debug_halted,
	// trace outputs
	output logic sync_req,
	output logic sample_req,
	output logic underflow_evt,
	output logic cpi_overflow_event_enable,
	output logic exception_trace_enable
);
	logic cycle_counter_enable_r, cycle_counter_enable_nxt;
	logic [3:0] post_reload_value_r, post_reload_value_nxt;
	logic [3:0] post_initial_value_r, post_initial_value_nxt;
	logic post_tap_select_r, post_tap_select_nxt;
	logic [1:0] sync_tap_select_r, sync_tap_select_nxt;
	logic periodic_sample_enable_r, periodic_sample_enable_nxt;
	logic exctrc_r, exctrc_nxt;
	logic cpievt_r, cpievt_nxt;
	logic underflow_event_enable_r, underflow_event_enable_nxt;
	logic [31:0] cyc_r, cyc_nxt;
	logic post_tap_r, post_tap_nxt;
	logic sync_bit_r, sync_bit_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic sync_req_r, sync_req_nxt;
	logic sample_r, sample_nxt;
	logic uflw_r, uflw_nxt;
	logic wr_ctrl, wr_cyc, timer_start, timer_run, timer_tick, timer_fire;
	logic [31:0] ctrl_view;
	logic [3:0] timer_count;

	function automatic logic pick_sync(input logic [31:0] c, input logic [1:0] sel);
		case (sel)
			2'h1: pick_sync = c[SYNC_TAP_A];
			2'h2: pick_sync = c[SYNC_TAP_B];
			2'h3: pick_sync = c[SYNC_TAP_C];
			default: pick_sync = 1'b0;
		endcase
	endfunction : pick_sync

	assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
	assign wr_cyc = reg_wr && reg_addr == OFS_CYC;

	// control register view; absent features read one in their NO flag and zero in their fields
	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[B_NOCYC] = !HAS_CYC;
		ctrl_view[B_NOPRF] = !HAS_PRF;
		ctrl_view[B_NOTRC] = !HAS_TRC;
		ctrl_view[B_UFLEVT] = underflow_event_enable_r;
		ctrl_view[B_CPIEVT] = cpievt_r;
		ctrl_view[B_EXCTRC] = exctrc_r;
		ctrl_view[B_SAMPLE] = periodic_sample_enable_r;
		ctrl_view[B_SYNC_LO +: 2] = sync_tap_select_r;
		ctrl_view[B_POSTTAP] = post_tap_select_r;
		ctrl_view[B_INIT_LO +: 4] = post_initial_value_r;
		ctrl_view[B_RELOAD_LO +: 4] = post_reload_value_r;
		ctrl_view[B_CYCENA] = cycle_counter_enable_r;
	end

	// control field writes
	always_comb begin
		cycle_counter_enable_nxt = cycle_counter_enable_r;
		post_reload_value_nxt = post_reload_value_r;
		post_initial_value_nxt = post_initial_value_r;
		post_tap_select_nxt = post_tap_select_r;
		sync_tap_select_nxt = sync_tap_select_r;
		periodic_sample_enable_nxt = periodic_sample_enable_r;
		exctrc_nxt = exctrc_r;
		cpievt_nxt = cpievt_r;
		underflow_event_enable_nxt = underflow_event_enable_r;
		if (wr_ctrl) begin
			if (HAS_PRF) begin
				cpievt_nxt = reg_wdata[B_CPIEVT];
			end
			if (HAS_TRC) begin
				exctrc_nxt = reg_wdata[B_EXCTRC];
			end
			if (HAS_CYC) begin
				cycle_counter_enable_nxt = reg_wdata[B_CYCENA];
				post_reload_value_nxt = reg_wdata[B_RELOAD_LO +: 4];
				post_tap_select_nxt = reg_wdata[B_POSTTAP];
				sync_tap_select_nxt = reg_wdata[B_SYNC_LO +: 2];
				if (!underflow_event_enable_r && !periodic_sample_enable_r) begin
					post_initial_value_nxt = reg_wdata[B_INIT_LO +: 4];
				end
				if (HAS_TRC) begin
					periodic_sample_enable_nxt = reg_wdata[B_SAMPLE];
					underflow_event_enable_nxt = reg_wdata[B_UFLEVT];
				end
			end
		end
	end

	// cycle counter and tap edge tracking
	always_comb begin
		cyc_nxt = cyc_r;
		if (wr_cyc && HAS_CYC) begin
			cyc_nxt = reg_wdata;
		end else if (cycle_counter_enable_r && !debug_halted && HAS_CYC) begin
			cyc_nxt = cyc_r + 32'h0000_0001;
		end
		post_tap_nxt = post_tap_select_r ? cyc_r[POST_TAP_HI] : cyc_r[POST_TAP_LO];
		sync_bit_nxt = pick_sync(cyc_r, sync_tap_select_r);
		sync_req_nxt = sync_tap_select_r != SYNC_OFF && sync_bit_nxt != sync_bit_r;
	end

	// timer starts only on none-to-one enable change; other changes keep the count
	assign timer_start = wr_ctrl && HAS_CYC && HAS_TRC && !underflow_event_enable_r
		&& !periodic_sample_enable_r && (reg_wdata[B_UFLEVT] ^ reg_wdata[B_SAMPLE]);
	assign timer_run = underflow_event_enable_r || periodic_sample_enable_r;
	assign timer_tick = post_tap_nxt != post_tap_r;

	wtu_post_timer u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.start(timer_start),
		.run(timer_run),
		.tick(timer_tick),
		.init_val(post_initial_value_r),
		.reload_val(post_reload_value_r),
		.fire(timer_fire),
		.count(timer_count)
	);

	always_comb begin
		sample_nxt = timer_fire && periodic_sample_enable_r;
		uflw_nxt = timer_fire && underflow_event_enable_r && !periodic_sample_enable_r;
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			if (reg_addr == OFS_CTRL) begin
				rdata_nxt = ctrl_view;
			end else if (reg_addr == OFS_CYC && HAS_CYC) begin
				rdata_nxt = cyc_r;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cycle_counter_enable_r <= 1'b0;
			post_reload_value_r <= NIB_RST;
			post_initial_value_r <= NIB_RST;
			post_tap_select_r <= 1'b0;
			sync_tap_select_r <= SYNC_OFF;
			periodic_sample_enable_r <= 1'b0;
			exctrc_r <= 1'b0;
			cpievt_r <= 1'b0;
			underflow_event_enable_r <= 1'b0;
			cyc_r <= CYC_RST;
			post_tap_r <= 1'b0;
			sync_bit_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			sync_req_r <= 1'b0;
			sample_r <= 1'b0;
			uflw_r <= 1'b0;
		end else begin
			cycle_counter_enable_r <= cycle_counter_enable_nxt;
			post_reload_value_r <= post_reload_value_nxt;
			post_initial_value_r <= post_initial_value_nxt;
			post_tap_select_r <= post_tap_select_nxt;
			sync_tap_select_r <= sync_tap_select_nxt;
			periodic_sample_enable_r <= periodic_sample_enable_nxt;
			exctrc_r <= exctrc_nxt;
			cpievt_r <= cpievt_nxt;
			underflow_event_enable_r <= underflow_event_enable_nxt;
			cyc_r <= cyc_nxt;
			post_tap_r <= post_tap_nxt;
			sync_bit_r <= sync_bit_nxt;
			rdata_r <= rdata_nxt;
			sync_req_r <= sync_req_nxt;
			sample_r <= sample_nxt;
			uflw_r <= uflw_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign sync_req = sync_req_r;
	assign sample_req = sample_r;
	assign underflow_evt = uflw_r;
	assign cpi_overflow_event_enable = cpievt_r;
	assign exception_trace_enable = exctrc_r;

	cyc_count_a: assert property (@(posedge core_clk) disable iff (srst)
		(cycle_counter_enable_r && !debug_halted && !wr_cyc) |=> cyc_r == $past(cyc_r) + 32'h0000_0001)
		else $error("cycle counter did not advance");
	cyc_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
		(cyc_r == 32'hFFFF_FFFF && cycle_counter_enable_r && !debug_halted && !wr_cyc) |=> cyc_r == 32'h0000_0000)
		else $error("cycle counter did not wrap");
	cyc_halt_a: assert property (@(posedge core_clk) disable iff (srst)
		(debug_halted && !wr_cyc) |=> $stable(cyc_r))
		else $error("cycle counter moved in debug state");
	cyc_write_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_cyc && HAS_CYC) |=> cyc_r == $past(reg_wdata))
		else $error("cycle count write lost");
	cyc_read_a: assert property (@(posedge core_clk) disable iff (srst)
		(reg_rd && reg_addr == OFS_CYC && HAS_CYC) |=> reg_rdata == $past(cyc_r))
		else $error("cycle count read wrong");
	init_guard_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_ctrl && (underflow_event_enable_r || periodic_sample_enable_r)) |=> $stable(post_initial_value_r))
		else $error("initial value written while timer on");
	cpi_bit_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_ctrl && HAS_PRF) |=> cpi_overflow_event_enable == $past(reg_wdata[B_CPIEVT]))
		else $error("cpi enable not taken");
	exc_bit_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_ctrl && HAS_TRC) |=> exception_trace_enable == $past(reg_wdata[B_EXCTRC]))
		else $error("exception trace enable not taken");
	sync_off_a: assert property (@(posedge core_clk) disable iff (srst)
		(sync_tap_select_r == SYNC_OFF) |=> !sync_req_r)
		else $error("sync request while disabled");
	uflw_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		periodic_sample_enable_r |=> !uflw_r)
		else $error("underflow event while sampling");

	// reset clears every enable, whatever the register held before
	rst_clear_a: assert property (@(posedge core_clk)
		srst |=> (!cycle_counter_enable_r && !periodic_sample_enable_r && !underflow_event_enable_r
			&& !cpi_overflow_event_enable && !exception_trace_enable && cyc_r == CYC_RST))
		else $error("control not cleared by reset");
	rdata_idle_a: assert property (@(posedge core_clk) disable iff (srst)
		!reg_rd
		|=> reg_rdata == 32'h0000_0000)
		else $error("read data stood without a read");
	ctrl_read_a: assert property (@(posedge core_clk) disable iff (srst)
		(reg_rd && reg_addr == OFS_CTRL)
		|=> (reg_rdata[B_NOCYC] == !HAS_CYC && reg_rdata[B_NOPRF] == !HAS_PRF
			&& reg_rdata[B_NOTRC] == !HAS_TRC))
		else $error("feature flags read wrong");
	init_take_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_ctrl && HAS_CYC && !underflow_event_enable_r && !periodic_sample_enable_r)
		|=> post_initial_value_r == $past(reg_wdata[B_INIT_LO +: 4]))
		else $error("initial value write lost while timer off");

	// timer start is a write step followed by a load step
	sequence start_write_s;
		wr_ctrl && HAS_CYC && HAS_TRC && !underflow_event_enable_r && !periodic_sample_enable_r
			&& reg_wdata[B_UFLEVT] != reg_wdata[B_SAMPLE];
	endsequence
	sequence init_loaded_s;
		timer_run && timer_count == $past(post_initial_value_r);
	endsequence
	sequence sample_fire_s;
		timer_fire && periodic_sample_enable_r;
	endsequence
	sequence underflow_fire_s;
		timer_fire && underflow_event_enable_r && !periodic_sample_enable_r;
	endsequence
	timer_load_a: assert property (@(posedge core_clk) disable iff (srst)
		start_write_s |=> init_loaded_s)
		else $error("timer not loaded on start");
	sample_out_a: assert property (@(posedge core_clk) disable iff (srst)
		sample_fire_s |=> sample_req)
		else $error("sample request missed");
	uflw_out_a: assert property (@(posedge core_clk) disable iff (srst)
		underflow_fire_s |=> underflow_evt)
		else $error("underflow event missed");
	timer_idle_a: assert property (@(posedge core_clk) disable iff (srst)
		!timer_run |=> (!sample_req && !underflow_evt))
		else $error("timer event while both enables off");
	post_tick_a: assert property (@(posedge core_clk) disable iff (srst)
		($stable(post_tap_select_r)
			&& (post_tap_select_r ? $changed(cyc_r[POST_TAP_HI]) : $changed(cyc_r[POST_TAP_LO])))
		|-> timer_tick)
		else $error("timer tick missed on tap change");

	sync_lo_a: assert property (@(posedge core_clk) disable iff (srst)
		(sync_tap_select_r == 2'h1 && $stable(sync_tap_select_r) && $changed(cyc_r[SYNC_TAP_A]))
		|=> sync_req)
		else $error("sync request missed at the low tap");
	sync_mid_a: assert property (@(posedge core_clk) disable iff (srst)
		(sync_tap_select_r == 2'h2 && $stable(sync_tap_select_r) && $changed(cyc_r[SYNC_TAP_B]))
		|=> sync_req)
		else $error("sync request missed at the middle tap");
	sync_hi_a: assert property (@(posedge core_clk) disable iff (srst)
		(sync_tap_select_r == 2'h3 && $stable(sync_tap_select_r) && $changed(cyc_r[SYNC_TAP_C]))
		|=> sync_req)
		else $error("sync request missed at the high tap");

	absent_cyc_a: assert property (@(posedge core_clk) disable iff (srst)
		(wr_ctrl && !HAS_CYC)
		|=> (!cycle_counter_enable_r && !periodic_sample_enable_r && !underflow_event_enable_r && !post_tap_select_r
			&& sync_tap_select_r == SYNC_OFF && post_initial_value_r == NIB_RST && post_reload_value_r == NIB_RST))
		else $error("field of the missing counter took a write");
	absent_cnt_a: assert property (@(posedge core_clk) disable iff (srst)
		(reg_rd && reg_addr == OFS_CYC && !HAS_CYC)
		|=> reg_rdata == 32'h0000_0000)
		else $error("missing counter read nonzero");
	absent_feat_a: assert property (@(posedge core_clk) disable iff (srst)
		wr_ctrl
		|=> ((HAS_PRF || !cpi_overflow_event_enable) && (HAS_TRC || !exception_trace_enable)))
		else $error("enable of a missing feature took a write");
endmodule : wtu_core

// File: hdl/wtu_pkg.sv
// package: register map, field layout and reset values of the watch trace unit
package wtu_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CYC = 4'h4;
	localparam int B_CYCENA = 0;
	localparam int B_RELOAD_LO = 1;
	localparam int B_INIT_LO = 5;
	localparam int B_POSTTAP = 9;
	localparam int B_SYNC_LO = 10;
	localparam int B_SAMPLE = 12;
	localparam int B_EXCTRC = 16;
	localparam int B_CPIEVT = 17;
	localparam int B_UFLEVT = 22;
	localparam int B_NOPRF = 24;
	localparam int B_NOCYC = 25;
	localparam int B_NOTRC = 27;
	localparam int POST_TAP_LO = 6;
	localparam int POST_TAP_HI = 10;
	localparam int SYNC_TAP_A = 24;
	localparam int SYNC_TAP_B = 26;
	localparam int SYNC_TAP_C = 28;
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic [1:0] SYNC_OFF = 2'h0;
	localparam logic [31:0] CYC_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		WTU_T_IDLE = 2'b00,
		WTU_T_RUN = 2'b01
	} wtu_tstate_t;
endpackage : wtu_pkg

// File: hdl/wtu_post_timer.sv
// post-divider timer: counts tap changes down, fires and reloads at zero
module wtu_post_timer
	import wtu_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// control
	input wire logic start,
	input wire logic run,
	input wire logic tick,
	input wire logic [3:0] init_val,
	input wire logic [3:0] reload_val,
	// result
	output logic fire,
	output logic [3:0] count
);
	wtu_tstate_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic fire_r, fire_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		fire_nxt = 1'b0;
		case (st_r)
			WTU_T_IDLE: begin
				if (start) begin
					cnt_nxt = init_val;
					st_nxt = WTU_T_RUN;
				end
			end
			WTU_T_RUN: begin
				// a restart may follow the stop back to back, before the stop has reached this state
				if (start) begin
					cnt_nxt = init_val;
				end else if (!run) begin
					st_nxt = WTU_T_IDLE;
				end else if (tick) begin
					if (cnt_r == 4'h0) begin
						fire_nxt = 1'b1;
						cnt_nxt = reload_val;
					end else begin
						cnt_nxt = cnt_r - 4'h1;
					end
				end
			end
			default: st_nxt = WTU_T_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= WTU_T_IDLE;
			cnt_r <= NIB_RST;
			fire_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			fire_r <= fire_nxt;
		end
	end

	assign fire = fire_r;
	assign count = cnt_r;

	reload_zero_a: assert property (@(posedge core_clk) disable iff (srst)
		(st_r == WTU_T_RUN && run && tick && cnt_r == 4'h0) |=> (fire_r && cnt_r == $past(reload_val)))
		else $error("timer did not fire and reload at zero");
endmodule : wtu_post_timer

// File: test/wtu_far_model.sv
// far side model: processor debug state and trace event sink
module wtu_far_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// processor core
	input wire logic halt_req,
	output logic debug_halted,
	// trace events
	input wire logic sync_req,
	input wire logic sample_req,
	input wire logic underflow_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	int t = 0, n_sync = 0, n_smp = 0, n_ufl = 0;
	int gap_smp = 0, gap_ufl = 0, last_smp = 0, last_ufl = 0;
	// core enters and leaves debug state on request, same clock
	assign debug_halted = halt_req;
	// only the latest gap is kept; the first one after reset is meaningless
	always @(posedge core_clk) begin
		t <= t + 1;
		if (srst) begin
			n_sync <= 0;
			n_smp <= 0;
			n_ufl <= 0;
		end
		else begin
			if (sync_req === 1'b1)
				n_sync <= n_sync + 1;
			if (sample_req === 1'b1) begin
				n_smp <= n_smp + 1;
				gap_smp <= t - last_smp;
				last_smp <= t;
			end
			if (underflow_evt === 1'b1) begin
				n_ufl <= n_ufl + 1;
				gap_ufl <= t - last_ufl;
				last_ufl <= t;
			end
		end
	end
endmodule : wtu_far_model

// File: test/tb.sv
// self-checking bench for the watch trace unit core
module tb;
	import wtu_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, halt_req = 0, rd_pend = 0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rdata2, wd;
	logic debug_halted, sync_req, sample_req, underflow_evt, cpi_en, exc_en, cpi2, exc2;
	logic [31:0] q[$], q2[$];
	logic [1:0] tap_t[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
	int bit_t[5] = '{24, 26, 28, 28, 24};
	int exp_t[5] = '{1, 1, 1, 0, 0};
	int seed = 32'h37AA0CD4, n_errors = 0, n_compared = 0, base = 0;
	initial forever #50 core_clk = ~core_clk;
	wtu_core uut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halted(debug_halted),
		.sync_req(sync_req), .sample_req(sample_req), .underflow_evt(underflow_evt),
		.cpi_overflow_event_enable(cpi_en), .exception_trace_enable(exc_en));
	// every optional feature left out: fields must stay dead
	wtu_core #(.HAS_CYC(1'b0), .HAS_PRF(1'b0), .HAS_TRC(1'b0)) uut_absent (.core_clk(core_clk),
		.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(rdata2), .debug_halted(debug_halted), .sync_req(), .sample_req(),
		.underflow_evt(), .cpi_overflow_event_enable(cpi2), .exception_trace_enable(exc2));
	wtu_far_model far (.core_clk(core_clk), .srst(srst), .halt_req(halt_req),
		.debug_halted(debug_halted), .sync_req(sync_req), .sample_req(sample_req),
		.underflow_evt(underflow_evt));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		q.push_back(e);
		q2.push_back(a == OFS_CTRL ? 32'h0B00_0000 : 32'h0000_0000);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge core_clk);
	endtask : rd
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask : idle
	// read data stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_pend) begin
			check("reg_rdata", reg_rdata, q.pop_front());
			check("reg_rdata_absent", rdata2, q2.pop_front());
		end
		rd_pend <= reg_rd;
	end
	initial begin
		#2_000_000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		rd(OFS_CTRL, 32'h0000_0000);
		rd(OFS_CYC, 32'h0000_0000);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			wd = $random(seed) & 32'hFFBF_EFFF;
			wr(OFS_CTRL, wd);
			rd(OFS_CTRL, wd & 32'h0003_0FFF);
			check("enables", {30'h0, cpi_en, exc_en}, {30'h0, wd[17:16]});
		end
		$display("test control fields done");
		halt_req <= 1'b1;
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_CYC, 32'hFFFF_FFFD);
		idle(4);
		rd(OFS_CYC, 32'hFFFF_FFFD);
		halt_req <= 1'b0;
		idle(4);
		rd(OFS_CYC, 32'h0000_0001);
		$display("test cycle counter done");
		for (int k = 0; k < 5; k++) begin
			wr(OFS_CTRL, {20'h0, tap_t[k], 10'h001});
			wr(OFS_CYC, (32'h1 << bit_t[k]) - 32'h20);
			idle(6);
			base = far.n_sync;
			idle(50);
			check("sync_count", far.n_sync - base, exp_t[k]);
		end
		$display("test sync taps done");
		// init first, then one enable alone
		wr(OFS_CTRL, 32'h0000_0065);
		wr(OFS_CTRL, 32'h0040_0065);
		idle(1000);
		check("underflow_gap", far.gap_ufl, 32'h0000_00C0);
		wr(OFS_CTRL, 32'h0040_00A5);
		rd(OFS_CTRL, 32'h0040_0065);
		wr(OFS_CTRL, 32'h0000_0223);
		rd(OFS_CTRL, 32'h0000_0263);
		// timer now off, so the new initial value is taken before the restart
		wr(OFS_CTRL, 32'h0000_0223);
		rd(OFS_CTRL, 32'h0000_0223);
		wr(OFS_CTRL, 32'h0000_1223);
		// both enables on: sampling goes on, underflow packets stay gated
		wr(OFS_CTRL, 32'h0040_1223);
		idle(2);
		base = far.n_ufl;
		idle(5000);
		check("sample_gap", far.gap_smp, 32'h0000_0800);
		check("underflow_quiet", far.n_ufl - base, 32'h0000_0000);
		$display("test post timer done");
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_CTRL, 32'hFFFF_FFFF);
		rd(OFS_CTRL, 32'h0043_1FFF);
		check("absent_enables", {30'h0, cpi2, exc2}, 32'h0000_0000);
		rd(4'h8, 32'h0000_0000);
		idle(3);
		$display("test absent features done");
		end_of_test();
	end
endmodule : tb
